/* File: core/pcf_defs.svh */
// Purpose: offsets, reset values, field positions and timing for the position filter block
// Assumes: 8-bit register address, 32-bit data, one word per register
// Notes: included by the package file; the modules use its macros through it
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH

`define CLK_NS 4
`define MS_NS 1000000

`define REG_CTRL 8'h00
`define REG_GEAR_TC 8'h04
`define REG_MED_TC 8'h08
`define REG_LP_TC 8'h0C
`define REG_COND_SEL 8'h10
`define REG_CPL_THR 8'h14
`define REG_PROX_THR 8'h18
`define REG_HOLD_MS 8'h1C
`define REG_DO_SEL 8'h20
`define REG_DO_STATE 8'h24
`define REG_ERR 8'h28
`define REG_IRQ_STAT 8'h2C
`define REG_IRQ_MASK 8'h30
`define REG_FILT_POS 8'h34
`define REG_GEAR_APP 8'h38

`define RST_GEAR_TC 16'h0000
`define RST_MED_TC 16'h0000
`define RST_LP_TC 16'h0014
`define RST_COND_SEL 3'h0
`define RST_CPL_THR 16'h000A
`define RST_PROX_THR 16'h00C8
`define RST_HOLD_MS 16'h0000
`define RST_DO_SEL 16'h0021

`define CTRL_FILT_SEL 0
`define NUM_DO 4
`define DO_SEL_W 4
`define DO_FN_CPL 4'h1
`define DO_FN_PROX 4'h2

`define IRQ_W 3
`define IRQ_CPL 0
`define IRQ_PROX 1
`define IRQ_GEAR 2

`define COND_ERR 3'h0
`define COND_SPD 3'h1
`define COND_FSPD 3'h2
`define COND_FSPD2 3'h3
`define COND_MSEG 3'h4

`endif

/* File: core/pcf_pkg.sv */
// Purpose: types shared by the position filter modules
// Assumes: constants come from pcf_defs.svh
// Notes: state structs follow the one-struct-per-module style
`include "pcf_defs.svh"

package pcf_pkg;

   typedef enum logic [2:0] {
      DET_IDLE = 3'h1,
      DET_HOLD = 3'h2,
      DET_DONE = 3'h4
   } det_state_t;

   typedef struct packed {
      det_state_t st;
      logic [15:0] cnt;
   } det_t;

   typedef struct packed {
      logic [31:0] s0;
      logic [31:0] s1;
      logic [31:0] s2;
      logic [31:0] med;
   } med_state_t;

   typedef struct packed {
      logic [31:0] tick_cnt;
      logic ms_tick;
      logic [1:0] ctrl;
      logic [15:0] gear_tc;
      logic [15:0] med_tc;
      logic [15:0] lp_tc;
      logic [2:0] cond_sel;
      logic [15:0] cpl_thr;
      logic [15:0] prox_thr;
      logic [15:0] hold_ms;
      logic [`NUM_DO*`DO_SEL_W-1:0] do_sel;
      logic [`NUM_DO-1:0] do_state;
      logic [`IRQ_W-1:0] irq_stat;
      logic [`IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
      logic [31:0] gear_tgt;
      logic [31:0] gear_app;
      logic [15:0] gear_rem;
      logic [31:0] cmd_pos;
      logic [31:0] lp_pos;
      logic [15:0] med_cnt;
      logic [31:0] filt_pos;
      logic [31:0] err_abs;
      det_t cpl;
      det_t prox;
   } core_state_t;

endpackage : pcf_pkg

/* File: core/median3_filter.sv */
// Purpose: median of the last three samples of the position command
// Assumes: take_in is a one-cycle pulse from the same clock
// Notes: output is registered and changes one cycle after a take
`timescale 1ns/1ns

module median3_filter
   import pcf_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic take_in,
   input wire logic [31:0] sample_in,
   output logic [31:0] med_out
);

   med_state_t st_ff;
   med_state_t nxt_st;

   function automatic logic [31:0] med3(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      logic signed [31:0] x;
      logic signed [31:0] y;
      logic signed [31:0] z;
      x = a;
      y = b;
      z = c;
      // ties count as in between, so two equal samples win over the third
      if ((x >= y && x <= z) || (x <= y && x >= z)) med3 = a;
      else if ((y >= x && y <= z) || (y <= x && y >= z)) med3 = b;
      else med3 = c;
   endfunction : med3

   always_comb begin
      nxt_st = st_ff;
      if (take_in) begin
         nxt_st.s0 = sample_in;
         nxt_st.s1 = st_ff.s0;
         nxt_st.s2 = st_ff.s1;
         nxt_st.med = med3(sample_in, st_ff.s0, st_ff.s1);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   assign med_out = st_ff.med;

endmodule : median3_filter

/* File: core/position_cmd_filter_inposition.sv */
// Purpose: gear-factor smoothing, position command filtering and in-position detection
// Assumes: all inputs come from logic on clk_sys_in; register port answers reads one cycle later
// Notes: positions are 32-bit two's complement encoder units, gear factor is unsigned Q16.16
// Functional notes
// [RULE1] A change of the gear factor is ramped linearly to the new value over the gear switch time in ms.
// [RULE2] Filtering acts on the command position after gear scaling, in encoder units.
// [RULE3] Software selects a first-order low-pass or a median filter, each with its own time constant.
// [RULE4] A larger time constant delays the filtered command more, so the following error grows.
// [RULE5] Completion asserts when the error meets the chosen condition for the whole hold time.
// [RULE6] Proximity asserts when the error stays within its threshold for the same hold time.
// [RULE7] Each digital output picks completion or proximity by its function code; states are readable.
// [RULE8] The completion threshold counts units of one ten-thousandth of a revolution.
// [RULE9] Condition select 0..4 picks error only, zero speed, zero filtered speed or command sent.
// [RULE10] Leaving a threshold before the hold expires restarts the hold and drops the output.
`timescale 1ns/1ns

module position_cmd_filter_inposition
   import pcf_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = `MS_NS / `CLK_NS
)
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic pos_mode_in,
   input wire logic cmd_valid_in,
   input wire logic [15:0] cmd_delta_in,
   input wire logic [31:0] pos_fb_in,
   input wire logic [31:0] gear_factor_in,
   input wire logic spd_cmd_zero_in,
   input wire logic spd_filt_zero_in,
   input wire logic multiseg_done_in,
   output logic [31:0] pos_filt_out,
   output logic [31:0] gear_applied_out,
   output logic [31:0] pos_err_abs_out,
   output logic completion_out,
   output logic proximity_out,
   output logic [`NUM_DO-1:0] do_out,
   output logic irq_out
);

   core_state_t st_ff;
   core_state_t nxt_st;
   logic med_take;
   logic [31:0] med_val;
   logic signed [48:0] scaled_prod;
   logic [31:0] err_raw;
   logic cpl_ok;
   logic prox_ok;
   logic [`IRQ_W-1:0] ev;
   logic [`DO_SEL_W-1:0] fn;

   // moves cur one n-th of the way to tgt; n is never zero here
   function automatic logic [31:0] ramp_step(input logic [31:0] cur, input logic [31:0] tgt,
                                             input logic [15:0] n);
      logic signed [32:0] diff;
      logic signed [32:0] q;
      diff = $signed({tgt[31], tgt}) - $signed({cur[31], cur});
      q = diff / $signed({17'h0, n});
      ramp_step = cur + q[31:0];
   endfunction : ramp_step

   // hold-time detector shared by completion and proximity
   function automatic det_t det_next(input det_t d, input logic ok, input logic tick,
                                     input logic [15:0] hold);
      det_t r;
      r = d;
      case (d.st)
         DET_IDLE: begin
            r.cnt = 16'h0000;
            if (ok) r.st = (hold == 16'h0000) ? DET_DONE : DET_HOLD;
         end
         DET_HOLD: begin
            if (!ok) begin
               r.st = DET_IDLE; // RULE10
               r.cnt = 16'h0000;
            end else if (tick) begin
               if (d.cnt + 16'h0001 >= hold) r.st = DET_DONE;
               else r.cnt = d.cnt + 16'h0001;
            end
         end
         DET_DONE: begin
            if (!ok) begin
               r.st = DET_IDLE; // RULE10
               r.cnt = 16'h0000;
            end
         end
         default: begin
            r.st = DET_IDLE;
            r.cnt = 16'h0000;
         end
      endcase
      det_next = r;
   endfunction : det_next

   function automatic core_state_t reset_state();
      core_state_t r;
      r = '0;
      r.gear_tc = `RST_GEAR_TC;
      r.med_tc = `RST_MED_TC;
      r.lp_tc = `RST_LP_TC;
      r.cond_sel = `RST_COND_SEL;
      r.cpl_thr = `RST_CPL_THR;
      r.prox_thr = `RST_PROX_THR;
      r.hold_ms = `RST_HOLD_MS;
      r.do_sel = `RST_DO_SEL;
      r.cpl.st = DET_IDLE;
      r.prox.st = DET_IDLE;
      return r;
   endfunction : reset_state

   median3_filter u_median (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .take_in(med_take),
      .sample_in(st_ff.cmd_pos),
      .med_out(med_val)
   );

   always_comb begin
      nxt_st = st_ff;
      ev = '0;
      fn = '0;
      med_take = 1'b0;

      // millisecond time base
      nxt_st.ms_tick = 1'b0;
      if (st_ff.tick_cnt >= CYC_PER_MS - 1) begin
         nxt_st.tick_cnt = 32'h00000000;
         nxt_st.ms_tick = 1'b1;
      end else begin
         nxt_st.tick_cnt = st_ff.tick_cnt + 32'h00000001;
      end

      // gear factor smoothing
      if (gear_factor_in != st_ff.gear_tgt) begin
         nxt_st.gear_tgt = gear_factor_in;
         nxt_st.gear_rem = st_ff.gear_tc; // RULE1
         if (st_ff.gear_tc == 16'h0000) begin
            nxt_st.gear_app = gear_factor_in;
            ev[`IRQ_GEAR] = 1'b1;
         end
      end else if (st_ff.ms_tick && st_ff.gear_rem != 16'h0000) begin
         nxt_st.gear_app = ramp_step(st_ff.gear_app, st_ff.gear_tgt, st_ff.gear_rem); // RULE1
         nxt_st.gear_rem = st_ff.gear_rem - 16'h0001;
         if (st_ff.gear_rem == 16'h0001) ev[`IRQ_GEAR] = 1'b1;
      end

      // command scaling ahead of the filters
      scaled_prod = $signed(cmd_delta_in) * $signed({1'b0, st_ff.gear_app});
      if (cmd_valid_in) nxt_st.cmd_pos = st_ff.cmd_pos + scaled_prod[47:16]; // RULE2

      // first-order low-pass, one step per ms
      if (st_ff.lp_tc == 16'h0000) begin
         nxt_st.lp_pos = st_ff.cmd_pos;
      end else if (st_ff.ms_tick) begin
         nxt_st.lp_pos = ramp_step(st_ff.lp_pos, st_ff.cmd_pos, st_ff.lp_tc); // RULE4
      end

      // median sampled every med_tc ms
      if (st_ff.ms_tick && st_ff.med_tc != 16'h0000) begin
         if (st_ff.med_cnt + 16'h0001 >= st_ff.med_tc) begin
            med_take = 1'b1; // RULE4
            nxt_st.med_cnt = 16'h0000;
         end else begin
            nxt_st.med_cnt = st_ff.med_cnt + 16'h0001;
         end
      end

      // filter select
      if (st_ff.ctrl[`CTRL_FILT_SEL]) begin
         nxt_st.filt_pos = (st_ff.med_tc == 16'h0000) ? st_ff.cmd_pos : med_val; // RULE3
      end else begin
         nxt_st.filt_pos = st_ff.lp_pos; // RULE3
      end

      // absolute position error
      err_raw = st_ff.filt_pos - pos_fb_in;
      nxt_st.err_abs = err_raw[31] ? (32'h00000000 - err_raw) : err_raw;

      // threshold in 1/10000 rev units, same scale as the error
      cpl_ok = pos_mode_in && (st_ff.err_abs <= {16'h0000, st_ff.cpl_thr}); // RULE8
      case (st_ff.cond_sel)
         `COND_ERR: cpl_ok = cpl_ok; // RULE9
         `COND_SPD: cpl_ok = cpl_ok && spd_cmd_zero_in; // RULE9
         `COND_FSPD: cpl_ok = cpl_ok && spd_filt_zero_in; // RULE9
         `COND_FSPD2: cpl_ok = cpl_ok && spd_filt_zero_in; // RULE9
         `COND_MSEG: cpl_ok = cpl_ok && multiseg_done_in; // RULE9
         default: cpl_ok = 1'b0;
      endcase
      prox_ok = pos_mode_in && (st_ff.err_abs <= {16'h0000, st_ff.prox_thr});

      nxt_st.cpl = det_next(st_ff.cpl, cpl_ok, st_ff.ms_tick, st_ff.hold_ms); // RULE5
      nxt_st.prox = det_next(st_ff.prox, prox_ok, st_ff.ms_tick, st_ff.hold_ms); // RULE6
      if (nxt_st.cpl.st == DET_DONE && st_ff.cpl.st != DET_DONE) ev[`IRQ_CPL] = 1'b1;
      if (nxt_st.prox.st == DET_DONE && st_ff.prox.st != DET_DONE) ev[`IRQ_PROX] = 1'b1;

      // digital output routing
      for (int i = 0; i < `NUM_DO; i++) begin
         fn = st_ff.do_sel[i*`DO_SEL_W +: `DO_SEL_W];
         if (fn == `DO_FN_CPL) nxt_st.do_state[i] = nxt_st.cpl.st == DET_DONE; // RULE7
         else if (fn == `DO_FN_PROX) nxt_st.do_state[i] = nxt_st.prox.st == DET_DONE; // RULE7
         else nxt_st.do_state[i] = 1'b0;
      end

      // register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            `REG_CTRL: nxt_st.ctrl = reg_wdata_in[1:0];
            `REG_GEAR_TC: nxt_st.gear_tc = reg_wdata_in[15:0];
            `REG_MED_TC: nxt_st.med_tc = reg_wdata_in[15:0];
            `REG_LP_TC: nxt_st.lp_tc = reg_wdata_in[15:0];
            `REG_COND_SEL: nxt_st.cond_sel = reg_wdata_in[2:0];
            `REG_CPL_THR: nxt_st.cpl_thr = reg_wdata_in[15:0];
            `REG_PROX_THR: nxt_st.prox_thr = reg_wdata_in[15:0];
            `REG_HOLD_MS: nxt_st.hold_ms = reg_wdata_in[15:0];
            `REG_DO_SEL: nxt_st.do_sel = reg_wdata_in[`NUM_DO*`DO_SEL_W-1:0];
            `REG_IRQ_MASK: nxt_st.irq_mask = reg_wdata_in[`IRQ_W-1:0];
            default: nxt_st.ctrl = nxt_st.ctrl;
         endcase
      end

      // sticky events, write one to clear, a new event wins
      nxt_st.irq_stat = st_ff.irq_stat;
      if (reg_wr_in && reg_addr_in == `REG_IRQ_STAT) begin
         nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata_in[`IRQ_W-1:0];
      end
      nxt_st.irq_stat = nxt_st.irq_stat | ev;

      // read data stands only in the cycle after the strobe
      nxt_st.rdata = 32'h00000000;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_CTRL: nxt_st.rdata = {30'h0, st_ff.ctrl};
            `REG_GEAR_TC: nxt_st.rdata = {16'h0000, st_ff.gear_tc};
            `REG_MED_TC: nxt_st.rdata = {16'h0000, st_ff.med_tc};
            `REG_LP_TC: nxt_st.rdata = {16'h0000, st_ff.lp_tc};
            `REG_COND_SEL: nxt_st.rdata = {29'h0, st_ff.cond_sel};
            `REG_CPL_THR: nxt_st.rdata = {16'h0000, st_ff.cpl_thr};
            `REG_PROX_THR: nxt_st.rdata = {16'h0000, st_ff.prox_thr};
            `REG_HOLD_MS: nxt_st.rdata = {16'h0000, st_ff.hold_ms};
            `REG_DO_SEL: nxt_st.rdata = {16'h0000, st_ff.do_sel};
            `REG_DO_STATE: nxt_st.rdata = {28'h0000000, st_ff.do_state}; // RULE7
            `REG_ERR: nxt_st.rdata = st_ff.err_abs;
            `REG_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.irq_stat};
            `REG_IRQ_MASK: nxt_st.rdata = {29'h0, st_ff.irq_mask};
            `REG_FILT_POS: nxt_st.rdata = st_ff.filt_pos;
            `REG_GEAR_APP: nxt_st.rdata = st_ff.gear_app;
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) st_ff <= reset_state();
      else st_ff <= nxt_st;
   end

   assign reg_rdata_out = st_ff.rdata;
   assign pos_filt_out = st_ff.filt_pos;
   assign gear_applied_out = st_ff.gear_app;
   assign pos_err_abs_out = st_ff.err_abs;
   assign completion_out = st_ff.cpl.st == DET_DONE; // RULE5
   assign proximity_out = st_ff.prox.st == DET_DONE; // RULE6
   assign do_out = st_ff.do_state;
   assign irq_out = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : position_cmd_filter_inposition

/* File: test/pcf_monitor.sv */
// Purpose: port-level assertions for the position filter block
// Assumes: one clock, synchronous active-low reset, at least 9 cycles per ms tick
// Notes: bound into position_cmd_filter_inposition by the bind below
`timescale 1ns/1ns

module pcf_monitor
   import pcf_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic pos_mode_in,
   input wire logic [31:0] pos_fb_in,
   input wire logic [31:0] pos_filt_out,
   input wire logic [31:0] gear_applied_out,
   input wire logic [31:0] pos_err_abs_out,
   input wire logic completion_out,
   input wire logic proximity_out,
   input wire logic [3:0] do_out,
   input wire logic irq_out
);
   logic [31:0] diff;
   logic [31:0] exp_err_ff;
   assign diff = pos_filt_out - pos_fb_in;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         exp_err_ff <= 32'h0;
      end else begin
         exp_err_ff <= diff[31] ? 32'h0 - diff : diff;
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_reset_quiet: assert property ($past(!rst_n_in) |-> !completion_out && !proximity_out && !irq_out)
      else $error("outputs active after reset");
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
      else $error("read data without read");
   a_unmapped_read: assert property (reg_rd_in && reg_addr_in > 8'h38 |=> reg_rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_err_read: assert property (reg_rd_in && reg_addr_in == 8'h28 |=> reg_rdata_out == $past(pos_err_abs_out))
      else $error("error readback wrong");
   a_err_abs_calc: assert property (pos_err_abs_out == exp_err_ff)
      else $error("absolute error wrong");
   a_mode_idle: assert property (!pos_mode_in |=> !completion_out && !proximity_out)
      else $error("detector active outside position mode");
   a_do_quiet: assert property (!completion_out && !proximity_out |-> do_out == 4'h0)
      else $error("output set with both detectors idle");
   a_gear_spaced: assert property (gear_applied_out != $past(gear_applied_out) |=> $stable(gear_applied_out)[*8])
      else $error("gear factor steps too fast");
   c_cpl: cover property ($rose(completion_out));
   c_prox: cover property ($rose(proximity_out));
   c_irq: cover property ($rose(irq_out));
endmodule : pcf_monitor

bind position_cmd_filter_inposition pcf_monitor i_mon (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out,
   .pos_mode_in, .pos_fb_in, .pos_filt_out, .gear_applied_out, .pos_err_abs_out, .completion_out, .proximity_out,
   .do_out, .irq_out);

/* File: test/pcf_host_model.sv */
// Purpose: host controller issuing command bursts and a motor that follows
// Assumes: one command per cycle during a burst
// Notes: feedback chases the filtered command by one unit a cycle; a kick adds 100
`timescale 1ns/1ns

module pcf_host_model
   import pcf_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic go_in,
   input wire logic [15:0] delta_in,
   input wire logic [7:0] count_in,
   input wire logic kick_in,
   input wire logic [31:0] pos_filt_in,
   output logic cmd_valid_out,
   output logic [15:0] cmd_delta_out,
   output logic [31:0] pos_fb_out
);
   logic [7:0] left_ff;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         left_ff <= 8'h00;
         cmd_valid_out <= 1'b0;
         cmd_delta_out <= 16'h0000;
         pos_fb_out <= 32'h0;
      end else begin
         left_ff <= go_in ? count_in : left_ff - 8'(left_ff != 8'h00);
         cmd_valid_out <= left_ff != 8'h00;
         // idle increment is scrambled so nothing relies on it
         cmd_delta_out <= (left_ff != 8'h00) ? delta_in : ~cmd_delta_out;
         if (kick_in) begin
            pos_fb_out <= pos_fb_out + 32'h64;
         end else if ($signed(pos_fb_out) < $signed(pos_filt_in)) begin
            pos_fb_out <= pos_fb_out + 32'h1;
         end else if ($signed(pos_fb_out) > $signed(pos_filt_in)) begin
            pos_fb_out <= pos_fb_out - 32'h1;
         end
      end
   end
endmodule : pcf_host_model

/* File: test/position_cmd_filter_inposition_tb.sv */
// Purpose: self-checking bench for the position filter block
// Assumes: one ms shortened to 10 cycles
// Notes: read data is compared against a queue of expected words
`timescale 1ns/1ns

module position_cmd_filter_inposition_tb;
   import pcf_pkg::*;
   localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30, 8'h3C};
   localparam logic [31:0] RV [11] = '{32'h0, 32'h0, 32'h0, 32'h14, 32'h0, 32'hA, 32'hC8, 32'h0, 32'h21, 32'h0, 32'h0};
   logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, pos_mode_in, spd_cmd_zero_in, spd_filt_zero_in;
   logic multiseg_done_in, cmd_valid_in, completion_out, proximity_out, irq_out, h_go, h_kick, rd_seen;
   logic [7:0] reg_addr_in, h_count;
   logic [15:0] cmd_delta_in, h_delta;
   logic [3:0] do_out;
   logic [31:0] reg_wdata_in, reg_rdata_out, pos_fb_in, gear_factor_in, pos_filt_out, gear_applied_out;
   logic [31:0] pos_err_abs_out, rnd, tgt;
   logic [31:0] exp_q [$];
   int bad_count, samples_checked, cyc;

   position_cmd_filter_inposition #(.CYC_PER_MS(10)) i_dut (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pos_mode_in, .cmd_valid_in, .cmd_delta_in, .pos_fb_in, .gear_factor_in,
      .spd_cmd_zero_in, .spd_filt_zero_in, .multiseg_done_in, .pos_filt_out, .gear_applied_out, .pos_err_abs_out,
      .completion_out, .proximity_out, .do_out, .irq_out);
   pcf_host_model i_host (.clk_sys_in, .rst_n_in, .go_in(h_go), .delta_in(h_delta), .count_in(h_count),
      .kick_in(h_kick), .pos_filt_in(pos_filt_out), .cmd_valid_out(cmd_valid_in), .cmd_delta_out(cmd_delta_in),
      .pos_fb_out(pos_fb_in));

   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : tick

   // w high writes d, low reads and notes d as the expected word
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      if (!w) exp_q.push_back(d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= w;
      reg_rd_in <= !w;
      @(posedge clk_sys_in);
      {reg_wr_in, reg_rd_in} <= 2'h0;
   endtask : bus

   task automatic move(input logic [15:0] d, input logic [7:0] n);
      tgt = tgt + 32'(d) * 32'(n) * (gear_factor_in >> 16);
      @(posedge clk_sys_in);
      h_delta <= d;
      h_count <= n;
      h_go <= 1'b1;
      @(posedge clk_sys_in);
      h_go <= 1'b0;
   endtask : move

   task automatic wait_for(input logic prox, input logic v);
      for (int i = 0; i < 3000 && (prox ? proximity_out : completion_out) !== v; i++) tick(1);
   endtask : wait_for

   always @(posedge clk_sys_in) begin
      cyc++;
      if (rd_seen) check("rdata", reg_rdata_out, exp_q.pop_front());
      rd_seen <= reg_rd_in;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end

   initial begin
      {rst_n_in, reg_wr_in, reg_rd_in, spd_cmd_zero_in, spd_filt_zero_in, multiseg_done_in, h_go, h_kick} = '0;
      {reg_addr_in, reg_wdata_in, h_delta, h_count, tgt} = '0;
      rd_seen = 1'b0;
      pos_mode_in = 1'b1;
      gear_factor_in = 32'h0001_0000;
      rnd = 32'h0000_BE56;
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 11; i++) bus(1'b0, RA[i], RV[i]);
      bus(1'b0, `REG_ERR, 32'h0);
      bus(1'b1, `REG_HOLD_MS, 32'h2);
      bus(1'b1, `REG_LP_TC, 32'h0);
      bus(1'b1, `REG_IRQ_MASK, 32'h3);
      bus(1'b1, `REG_IRQ_STAT, 32'h7);
      rnd = xs(rnd);
      move(16'h10 + 16'(rnd[3:0]), 8'h14);
      wait_for(1'b1, 1'b0);
      wait_for(1'b1, 1'b1);
      check("cpl", 32'(completion_out), 32'h0);
      wait_for(1'b0, 1'b1);
      check("err", 32'(pos_err_abs_out <= 32'hA), 32'h1);
      check("irq", 32'(irq_out), 32'h1);
      bus(1'b0, `REG_IRQ_STAT, 32'h3);
      bus(1'b1, `REG_IRQ_STAT, 32'h3);
      tick(2);
      check("irq", 32'(irq_out), 32'h0);
      @(posedge clk_sys_in);
      h_kick <= 1'b1;
      @(posedge clk_sys_in);
      h_kick <= 1'b0;
      tick(4);
      check("cpl", 32'(completion_out), 32'h0);
      check("prox", 32'(proximity_out), 32'h1);
      wait_for(1'b0, 1'b1);
      bus(1'b1, `REG_DO_SEL, 32'h1012);
      tick(2);
      check("do", 32'(do_out), 32'hB);
      bus(1'b0, `REG_DO_STATE, 32'hB);
      // code 5 lies outside the decoded range and must never complete
      for (int c = 0; c < 6; c++) begin
         bus(1'b1, `REG_COND_SEL, 32'(c));
         tick(60);
         check("cpl", 32'(completion_out), 32'(c == 0));
         spd_cmd_zero_in <= (c == 1);
         spd_filt_zero_in <= (c == 2 || c == 3);
         multiseg_done_in <= (c == 4);
         tick(60);
         check("cpl", 32'(completion_out), 32'(c < 5));
         {spd_cmd_zero_in, spd_filt_zero_in, multiseg_done_in} <= 3'h0;
      end
      bus(1'b1, `REG_COND_SEL, 32'h0);
      move(16'h03E8, 8'h1);
      tick(8);
      check("filt", pos_filt_out, tgt);
      bus(1'b1, `REG_LP_TC, 32'h4);
      move(16'h03E8, 8'h1);
      tick(8);
      check("lag", 32'(pos_filt_out !== tgt), 32'h1);
      bus(1'b1, `REG_CTRL, 32'h1);
      bus(1'b1, `REG_MED_TC, 32'h1);
      tick(60);
      check("med", pos_filt_out, tgt);
      move(16'h03E8, 8'h1);
      tick(5);
      check("med", pos_filt_out, tgt - 32'h3E8);
      // by now two samples of the new value have been taken, so it is the median
      tick(18);
      check("med", pos_filt_out, tgt);
      bus(1'b1, `REG_GEAR_TC, 32'h4);
      gear_factor_in <= 32'h0002_0000;
      tick(15);
      check("gear", 32'(gear_applied_out > 32'h10000 && gear_applied_out < 32'h20000), 32'h1);
      tick(40);
      check("gear", gear_applied_out, 32'h20000);
      bus(1'b0, `REG_GEAR_APP, 32'h20000);
      move(16'h5, 8'h1);
      tick(40);
      check("scale", pos_filt_out, tgt);
      bus(1'b0, `REG_FILT_POS, tgt);
      bus(1'b1, `REG_IRQ_MASK, 32'h4);
      tick(2);
      check("irq", 32'(irq_out), 32'h1);
      bus(1'b1, `REG_IRQ_MASK, 32'h0);
      tick(2);
      check("irq", 32'(irq_out), 32'h0);
      pos_mode_in <= 1'b0;
      tick(3);
      check("do", 32'(do_out), 32'h0);
      test_done();
   end
endmodule : position_cmd_filter_inposition_tb
